// ==== ddr3_sdram_command_interface_tb.sv ====
// Self-checking bench: controller end and device end joined by the link
`timescale 1ns/1ps
module ddr3_sdram_command_interface_tb;
    import ddr_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        chk = 1'b0;
    logic        chk_q = 1'b0;
    logic [31:0] rdata;
    logic [31:0] seed = 32'h7fbe;
    logic [7:0]  bank_open;
    logic        power_down;
    logic        self_refresh;
    logic [7:0]  mem [128];
    logic        known [128];
    logic [63:0] notes [$];
    int          miscompares = 0;
    int          check_count = 0;
    int          refs = 0;
    wire  [31:0] dev_st = {14'h0, self_refresh, power_down, 8'h0, bank_open};
    ddr_link_if  link ();
    ddr_ctl_end  ddr_ctl_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .addr(addr),
                                .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    ddr_dev_end  ddr_dev_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
                                .bank_open(bank_open), .power_down(power_down),
                                .self_refresh(self_refresh));
    ddr_link_sva ddr_link_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .ck(link.ck),
                                 .ck_n(link.ck_n), .cs_n(link.cs_n), .dq_d_oe(link.dq_d_oe),
                                 .dqs_d(link.dqs_d), .dqs_n_d(link.dqs_n_d),
                                 .dq_h_oe(link.dq_h_oe), .dqs_h_oe(link.dqs_h_oe));
    always #5 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] care);
        check_count++;
        if ((got & care) !== (exp & care)) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Only reads with a nonzero care mask leave a note for the monitor
    task automatic br(input logic [7:0] a, input logic [31:0] e, c, output logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        chk <= |c;
        if (|c) notes.push_back({c, e});
        @(posedge ref_clk);
        rd <= 1'b0;
        chk <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic cmd(input cmd_t op, input logic k, input logic [2:0] b, input logic [13:0] a);
        logic [31:0] s;
        bw(OFS_ADDR, {13'h0, b, 2'h0, a});
        bw(OFS_CMD, {23'h0, k, 5'h0, op});
        s = 32'h1;
        for (int n = 0; n < 400 && s[0] !== 1'b0; n++) br(OFS_STATUS, 0, 0, s);
        if (s[0] !== 1'b0) miscompares++;
    endtask
    // Flags follow the link with synchroniser lag, so poll under a bound
    task automatic dev_is(input logic [31:0] e);
        for (int n = 0; n < 64 && dev_st !== e; n++) @(posedge ref_clk);
        cmp(dev_st, e, '1);
    endtask
    always @(posedge ref_clk) begin
        if (chk_q) begin
            cmp(rdata, notes[0][31:0], notes[0][63:32]);
            void'(notes.pop_front());
        end
        chk_q <= chk;
    end
    // Refresh commands on the pins, one count per selected cycle
    always @(posedge ref_clk) begin
        if (!link.cs_n && {link.ras_n, link.cas_n, link.we_n} == CMD_REF) refs++;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #800000;
        miscompares++;
        complete_run();
    end
    initial begin
        logic [31:0] v;
        logic [63:0] dd, ex, cr;
        logic [9:0]  w, c;
        logic [7:0]  m;
        logic [6:0]  p;
        logic [4:0]  cl, cwl, al;
        logic [2:0]  b;
        logic        r, ch;
        for (int i = 0; i < 128; i++) known[i] = 1'b0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        br(OFS_CFG, CFG_RST, '1, v);
        br(8'h24, 0, '1, v);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            cl = 5'(5 + 2 * i);
            cwl = 5'(5 + i);
            al = (i % 3 == 0) ? 5'h0 : cl - 5'(i % 3);
            ch = (i == 1 || i == 2);
            seed = lfsr(seed);
            {m, c, w, r, b} = seed;
            dd[31:0] = lfsr(seed);
            seed = lfsr(dd[31:0]);
            dd[63:32] = seed;
            cmd(CMD_MRS, 1, 0, {7'h0, 3'(cl - 4), 1'(i), 1'b0, 2'(ch ? i : 0)});
            cmd(CMD_MRS, 1, 1, {9'h0, 2'(i % 3), 3'h0});
            cmd(CMD_MRS, 1, 2, {9'h0, 2'(cwl - 5), 3'h0});
            bw(OFS_CFG, {15'h0, ch, 3'h0, al + cwl, 3'h0, al + cl});
            cmd(CMD_ACT, 1, b, {13'h0, r});
            dev_is(32'h1 << b);
            bw(OFS_WD0, dd[31:0]);
            bw(OFS_WD1, dd[63:32]);
            bw(OFS_WMASK, {24'h0, m});
            cmd(CMD_WR, 1, b, {1'b0, !ch, 2'h0, w});
            for (int j = 0; j < (ch ? 4 : 8); j++)
                if (!m[j]) begin
                    mem[{r, b, 3'(w[2:0] + j)}] = dd[8*j+:8];
                    known[{r, b, 3'(w[2:0] + j)}] = 1'b1;
                end
            cmd(CMD_RD, 1, b, {1'b0, !ch, 2'h1, c});
            ex = '0;
            cr = '0;
            for (int k = 0; k < (ch ? 4 : 8); k++) begin
                p = {r, b, (i % 2) ? c[2:0] ^ 3'(k) : c[2:0] + 3'(k)};
                ex[8*k+:8] = mem[p];
                cr[8*k+:8] = {8{known[p]}};
            end
            br(OFS_RD0, ex[31:0], cr[31:0], v);
            br(OFS_RD1, ex[63:32], cr[63:32], v);
            dev_is(0);
            $display("burst test %0d done", i);
        end
        cmd(CMD_ACT, 1, 1, 0);
        cmd(CMD_ACT, 1, 2, 0);
        cmd(CMD_PRE, 1, 1, 0);
        dev_is(32'h04);
        cmd(CMD_PRE, 1, 0, 14'h0400);
        dev_is(0);
        cmd(CMD_NOP, 0, 0, 0);
        dev_is(32'h10000);
        cmd(CMD_NOP, 1, 0, 0);
        dev_is(0);
        cmd(CMD_REF, 0, 0, 0);
        dev_is(32'h20000);
        cmd(CMD_NOP, 1, 0, 0);
        dev_is(0);
        $display("bank and power test done");
        // Hot pacing: first due after the normal span, then the short one
        bw(OFS_CFG, 32'h0006_0505);
        repeat (1300) @(posedge ref_clk);
        bw(OFS_CFG, CFG_RST);
        cmp(refs, 32'h18, '1);
        $display("refresh test done");
        complete_run();
    end
endmodule

// ==== ddr_ctl_end.sv ====
// DDR3 controller end: link clock, command issue, bursts, refresh timer
`timescale 1ns/1ps
module ddr_ctl_end
    import ddr_pkg::*;
(
    input  logic        ref_clk,
    input  logic        sys_rst,
    ddr_link_if.ctl     link,
    input  logic [7:0]  addr,
    input  logic [31:0] wdata,
    input  logic        wr,
    input  logic        rd,
    output logic [31:0] rdata
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_ISSUE = 3'b001, H_HOLD = 3'b011,
        H_LAT = 3'b010, H_BURST = 3'b110
    } h_st_t;
    typedef struct packed {
        h_st_t                st;
        logic [2:0]           cnt;
        logic                 ck, ck_n, dqs_p;
        logic                 cke, cs_n, ras_n, cas_n, we_n, dm;
        logic [BA_W-1:0]      ba;
        logic [A_W-1:0]       a;
        logic [DQ_W-1:0]      dq;
        logic                 dq_oe, dqs, dqs_oe;
        cmd_t                 pcmd;
        logic                 pcke;
        logic [18:0]          areg;
        logic [7:0][7:0]      wd, rdq;
        logic [7:0]           wmask;
        logic [31:0]          cfg, rdata;
        logic [4:0]           lat;
        logic [3:0]           beat;
        logic                 rd_done, ref_due;
        logic [9:0]           refc;
    } st_t;
    localparam st_t RST_ST = '{cfg: CFG_RST, cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                               cas_n: 1'b1, we_n: 1'b1, ck_n: 1'b1,
                               st: H_IDLE, pcmd: CMD_NOP, refc: REFI_NORM_CYC, default: '0};

    st_t             r, n;
    logic [DQ_W:0]   s;
    logic            wrap, rise, fall, dqs_e, is_wr, take;
    logic [3:0]      beats;

    ddr_sync #(.W(DQ_W + 1)) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .d       ({link.dq, link.dqs}),
        .q       (s)
    );

    always_comb begin
        n       = r;
        wrap    = (r.cnt == CK_HALF - 3'h1);
        rise    = wrap & ~r.ck;
        fall    = wrap & r.ck;
        n.cnt   = wrap ? 3'h0 : r.cnt + 3'h1;
        n.ck    = r.ck ^ wrap;
        n.ck_n  = ~(r.ck ^ wrap);
        dqs_e   = s[0] ^ r.dqs_p;
        n.dqs_p = s[0];
        is_wr   = (r.pcmd == CMD_WR);
        beats   = r.cfg[CFG_BC4_BIT] ? BEATS_BC4 : BEATS_BL8;
        take    = wr && (addr == OFS_CMD) && (r.st == H_IDLE);

        // Refresh pacing; a new due wins over the clear
        if (r.st == H_ISSUE && r.pcmd == CMD_REF) begin
            n.ref_due = 1'b0;
        end
        if (!r.cfg[CFG_REF_BIT]) begin
            n.refc = REFI_NORM_CYC - 10'h001;
        end else if (r.refc == 10'h000) begin
            n.ref_due = 1'b1;
            // Reload one short: the zero count is a cycle too
            n.refc    = (r.cfg[CFG_HOT_BIT] ? REFI_HOT_CYC : REFI_NORM_CYC) - 10'h001;
        end else begin
            n.refc = r.refc - 10'h001;
        end

        if (wr) begin
            unique case (addr)
                OFS_ADDR:  n.areg = wdata[18:0];
                OFS_WD0:   n.wd[3:0] = wdata;
                OFS_WD1:   n.wd[7:4] = wdata;
                OFS_WMASK: n.wmask = wdata[7:0];
                OFS_CFG:   n.cfg = wdata;
                default:   n.cfg = n.cfg;
            endcase
        end
        n.rdata = '0;
        if (rd) begin
            unique case (addr)
                OFS_ADDR:   n.rdata = 32'(r.areg);
                OFS_CFG:    n.rdata = r.cfg;
                OFS_RD0:    n.rdata = r.rdq[3:0];
                OFS_RD1:    n.rdata = r.rdq[7:4];
                OFS_STATUS: n.rdata = {30'h0, r.rd_done, r.st != H_IDLE};
                default:    n.rdata = '0;
            endcase
        end

        unique case (r.st)
            H_IDLE: begin
                if (take) begin
                    // Software keeps bank order and idle-bank power entry
                    n.pcmd    = cmd_t'(wdata[2:0]);
                    n.pcke    = wdata[CMD_CKE_BIT];
                    n.rd_done = 1'b0;
                    n.st      = H_ISSUE;
                end else if (r.ref_due && r.cke) begin
                    n.pcmd = CMD_REF;
                    n.pcke = 1'b1;
                    n.st   = H_ISSUE;
                end
            end
            H_ISSUE: begin
                // Launch on the falling edge so pins are settled at the rise
                if (fall) begin
                    n.cs_n = 1'b0;
                    {n.ras_n, n.cas_n, n.we_n} = r.pcmd;
                    n.ba  = r.areg[ADDR_BA_LSB +: BA_W];
                    n.a   = r.areg[A_W-1:0];
                    n.cke = r.pcke;
                    n.lat = is_wr ? r.cfg[CFG_WL_LSB +: 5] : r.cfg[CFG_RL_LSB +: 5];
                    n.st  = H_HOLD;
                end
            end
            H_HOLD: begin
                if (rise) begin
                    n.lat = r.lat - 5'h01;
                end
                if (fall) begin
                    n.cs_n = 1'b1;
                    n.st   = (r.pcmd == CMD_RD || is_wr) ? H_LAT : H_IDLE;
                end
            end
            H_LAT: begin
                if (rise) begin
                    if (r.lat == 5'h00) begin
                        n.st   = H_BURST;
                        n.beat = 4'h0;
                        if (is_wr) begin
                            n.dq     = r.wd[0];
                            n.dm     = r.wmask[0];
                            n.dq_oe  = 1'b1;
                            n.dqs_oe = 1'b1;
                            n.beat   = 4'h1;
                        end
                    end else begin
                        n.lat = r.lat - 5'h01;
                    end
                end
            end
            H_BURST: begin
                if (is_wr) begin
                    // Strobe toggles mid-beat: center aligned write data
                    if (r.cnt == DQS_MID) begin
                        n.dqs = ~r.dqs;
                    end
                    if (wrap) begin
                        if (r.beat == beats) begin
                            n.dq_oe  = 1'b0;
                            n.dqs_oe = 1'b0;
                            n.dm     = 1'b0;
                            n.st     = H_IDLE;
                        end else begin
                            n.dq   = r.wd[r.beat[2:0]];
                            n.dm   = r.wmask[r.beat[2:0]];
                            n.beat = r.beat + 4'h1;
                        end
                    end
                end else if (dqs_e) begin
                    // No timeout: a silent device leaves the read waiting
                    n.rdq[r.beat[2:0]] = s[DQ_W:1];
                    n.beat = r.beat + 4'h1;
                    if (r.beat == beats - 4'h1) begin
                        n.rd_done = 1'b1;
                        n.st      = H_IDLE;
                    end
                end
            end
            default: n.st = H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= RST_ST;
        end else begin
            r <= n;
        end
    end

    assign link.ck       = r.ck;
    assign link.ck_n     = r.ck_n;
    assign link.cke      = r.cke;
    assign link.cs_n     = r.cs_n;
    assign link.ras_n    = r.ras_n;
    assign link.cas_n    = r.cas_n;
    assign link.we_n     = r.we_n;
    assign link.ba       = r.ba;
    assign link.a        = r.a;
    assign link.dm       = r.dm;
    assign link.dq_h     = r.dq;
    assign link.dq_h_oe  = r.dq_oe;
    assign link.dqs_h    = r.dqs;
    assign link.dqs_n_h  = ~r.dqs;
    assign link.dqs_h_oe = r.dqs_oe;
    assign rdata         = r.rdata;
endmodule

// ==== ddr_dev_end.sv ====
// DDR3 device end: command decode, latencies, DDR data and small array
`timescale 1ns/1ps
// What this block does
// - Chip select high masks the command
// - Row strobe low: activate or precharge
// - Column strobe low: read or write
// - Sample inputs at rising clock crossing
// - Clock enable low freezes internal state
// - Low power entered only with banks idle
// - Bank address picks one of eight banks
// - Row on activate, column on access
// - Mode register opcode from address
// - Address bit ten requests auto-precharge
// - Address bit ten precharges all banks
// - Address bit twelve low chops burst
// - Bursts of eight or chopped four
// - CAS latency four through eleven
// - Additive latency zero, CL-1, CL-2
// - Read data after additive plus CAS
// - Write data after additive plus write
// - Controller refreshes every 7.8 or 3.9 us
// - Read order interleaved or sequential
// - Data on both strobe edges
// - Masked write bytes left unchanged
// - Termination strobe disables data mask
module ddr_dev_end
    import ddr_pkg::*;
(
    input  logic           ref_clk,
    input  logic           sys_rst,
    ddr_link_if.dev        link,
    output logic [7:0]     bank_open,
    output logic           power_down,
    output logic           self_refresh
);
    typedef struct packed {
        logic             ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
        logic [BA_W-1:0]  ba;
        logic [A_W-1:0]   a;
        logic             dm;
        logic [DQ_W-1:0]  dq;
        logic             dqs;
    } pin_t;
    typedef struct packed {
        logic             wr, ap, bc;
        logic [BA_W-1:0]  ba;
        logic [COL_W-1:0] col;
    } colop_t;
    typedef struct packed {
        logic                            ckx_p, dqs_p;
        logic [A_W-1:0]                  mr0, mr1, mr2;
        logic [7:0]                      open;
        logic [7:0][A_W-1:0]             row;
        logic                            pend;
        logic [4:0]                      lat;
        colop_t                          pop, cur;
        logic                            rd_act, wr_act;
        logic [3:0]                      beat;
        logic                            frozen, pdn, srf;
        logic [DQ_W-1:0]                 dq_o;
        logic                            dq_oe, dqs_o, dqs_n_o, dqs_oe, tdqs_o;
        logic [MEM_DEPTH-1:0][DQ_W-1:0]  mem;
    } st_t;
    localparam st_t RST_ST = '{mr0: MR0_RST, default: '0};

    pin_t            p;
    st_t             r, n;
    logic            ckx, rise, fall, edge_ok, dqs_e, start, tdqs_en;
    logic [4:0]      cl, cwl, al;
    logic [3:0]      beats, rbeat;
    cmd_t            cmd;
    colop_t          op;
    logic [MEM_AW-1:0] idx;

    ddr_sync #(.W($bits(pin_t))) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .d       ({link.ck, link.ck_n, link.cke, link.cs_n, link.ras_n, link.cas_n,
                   link.we_n, link.ba, link.a, link.dm, link.dq, link.dqs}),
        .q       (p)
    );

    function automatic logic [MEM_AW-1:0] addr_of(colop_t o, logic [A_W-1:0] rw,
                                                   logic [2:0] b, logic il);
        logic [2:0] c;
        c = il ? (o.col[2:0] ^ b) : 3'(o.col[2:0] + b);
        return {rw[0], o.ba, c};
    endfunction

    always_comb begin
        n       = r;
        cl      = 5'(r.mr0[MR0_CL_LSB +: 3]) + CL_BASE;
        cwl     = 5'(r.mr2[MR2_CWL_LSB +: 2]) + CWL_BASE;
        unique case (r.mr1[MR1_AL_LSB +: 2])
            AL_CL1:  al = cl - 5'h01;
            AL_CL2:  al = cl - 5'h02;
            default: al = 5'h00;
        endcase
        tdqs_en = r.mr1[MR1_TDQS_BIT];
        cmd     = cmd_t'({p.ras_n, p.cas_n, p.we_n});
        ckx     = p.ck & ~p.ck_n;
        rise    = ckx & ~r.ckx_p;
        fall    = ~ckx & r.ckx_p;
        edge_ok = (rise | fall) & ~r.frozen;
        dqs_e   = (p.dqs ^ r.dqs_p) & ~r.frozen;
        n.ckx_p = ckx;
        n.dqs_p = p.dqs;
        start   = rise & ~r.frozen & r.pend & (r.lat == 5'h00);
        op      = start ? r.pop : r.cur;
        beats   = op.bc ? BEATS_BC4 : BEATS_BL8;
        rbeat   = start ? 4'h0 : r.beat;
        idx     = addr_of(op, r.row[op.ba], rbeat[2:0],
                          r.mr0[MR0_BT_BIT] & ~op.wr);

        // Latency countdown of the posted column command
        if (rise && !r.frozen && r.pend) begin
            if (start) begin
                n.pend   = 1'b0;
                n.cur    = r.pop;
                n.wr_act = r.pop.wr;
                n.beat   = 4'h0;
            end else begin
                n.lat = r.lat - 5'h01;
            end
        end

        // Read beats edge aligned with the strobe
        if (edge_ok && (r.rd_act || (start && !r.pop.wr))) begin
            if (rbeat == beats) begin
                n.rd_act = 1'b0;
                n.dq_oe  = 1'b0;
                n.dqs_oe = 1'b0;
                if (op.ap) begin
                    n.open[op.ba] = 1'b0;
                end
            end else begin
                n.rd_act  = 1'b1;
                n.dq_o    = r.mem[idx];
                n.dqs_o   = rise;
                n.dqs_n_o = ~rise;
                n.dq_oe   = 1'b1;
                n.dqs_oe  = 1'b1;
                n.beat    = rbeat + 4'h1;
            end
        end

        // Write beats captured on each strobe edge
        if (dqs_e && r.wr_act) begin
            if (!(p.dm && !tdqs_en)) begin
                n.mem[idx] = p.dq;
            end
            n.beat = r.beat + 4'h1;
            if (r.beat == beats - 4'h1) begin
                n.wr_act = 1'b0;
                if (r.cur.ap) begin
                    n.open[r.cur.ba] = 1'b0;
                end
            end
        end

        if (rise && r.frozen) begin
            if (p.cke) begin
                n.frozen = 1'b0;
                n.pdn    = 1'b0;
                n.srf    = 1'b0;
            end
        end else if (rise) begin
            if (!p.cs_n) begin
                unique case (cmd)
                    CMD_MRS: begin
                        unique case (p.ba[1:0])
                            2'h0:    n.mr0 = p.a;
                            2'h1:    n.mr1 = p.a;
                            2'h2:    n.mr2 = p.a;
                            default: n.mr0 = r.mr0;
                        endcase
                    end
                    CMD_ACT: begin
                        n.open[p.ba] = 1'b1;
                        n.row[p.ba]  = p.a;
                    end
                    CMD_PRE: begin
                        if (p.a[AP_BIT]) begin
                            n.open = '0;
                        end else begin
                            n.open[p.ba] = 1'b0;
                        end
                    end
                    CMD_RD, CMD_WR: begin
                        n.pend   = 1'b1;
                        n.pop.wr = (cmd == CMD_WR);
                        n.pop.ap = p.a[AP_BIT];
                        unique case (r.mr0[MR0_BL_LSB +: 2])
                            BL_OTF:  n.pop.bc = ~p.a[BC_BIT];
                            BL_FIX4: n.pop.bc = 1'b1;
                            default: n.pop.bc = 1'b0;
                        endcase
                        n.pop.ba  = p.ba;
                        n.pop.col = p.a[COL_W-1:0];
                        n.lat     = (cmd == CMD_WR) ? al + cwl - 5'h01
                                                    : al + cl - 5'h01;
                    end
                    default: n.pend = n.pend;
                endcase
            end
            if (!p.cke) begin
                n.frozen = 1'b1;
                if (r.open == '0) begin
                    if (!p.cs_n && cmd == CMD_REF) begin
                        n.srf = 1'b1;
                    end else begin
                        n.pdn = 1'b1;
                    end
                end
            end
        end
        n.tdqs_o = tdqs_en;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= RST_ST;
        end else begin
            r <= n;
        end
    end

    assign link.dq_d     = r.dq_o;
    assign link.dq_d_oe  = r.dq_oe;
    assign link.dqs_d    = r.dqs_o;
    assign link.dqs_n_d  = r.dqs_n_o;
    assign link.dqs_d_oe = r.dqs_oe;
    assign link.tdqs     = r.tdqs_o;
    assign link.tdqs_n   = r.tdqs_o;
    assign bank_open     = r.open;
    assign power_down    = r.pdn;
    assign self_refresh  = r.srf;
endmodule

// ==== ddr_link_if.sv ====
// Pin-level link between the DDR3 device end and its controller end
`timescale 1ns/1ps
interface ddr_link_if;
    import ddr_pkg::*;
    logic            ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, dm;
    logic [BA_W-1:0] ba;
    logic [A_W-1:0]  a;
    logic [DQ_W-1:0] dq_h, dq_d, dq;
    logic            dq_h_oe, dq_d_oe;
    logic            dqs_h, dqs_n_h, dqs_h_oe, dqs_d, dqs_n_d, dqs_d_oe;
    logic            dqs, dqs_n, tdqs, tdqs_n;
    // Undriven lines settle at the strobe's idle level
    assign dq    = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : '0);
    assign dqs   = dqs_d_oe ? dqs_d : (dqs_h_oe ? dqs_h : 1'b0);
    assign dqs_n = dqs_d_oe ? dqs_n_d : (dqs_h_oe ? dqs_n_h : 1'b1);
    modport dev (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, a, dm, dq, dqs,
                 output dq_d, dq_d_oe, dqs_d, dqs_n_d, dqs_d_oe, tdqs, tdqs_n);
    modport ctl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, a, dm,
                 output dq_h, dq_h_oe, dqs_h, dqs_n_h, dqs_h_oe,
                 input dq, dqs);
endinterface

// ==== ddr_link_sva.sv ====
// Pin-level checks on the link between the two DDR3 ends
`timescale 1ns/1ps
module ddr_link_sva (
    input logic ref_clk,
    input logic sys_rst,
    input logic ck,
    input logic ck_n,
    input logic cs_n,
    input logic dq_d_oe,
    input logic dqs_d,
    input logic dqs_n_d,
    input logic dq_h_oe,
    input logic dqs_h_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_ck_pair; ck_n == !ck; endproperty
    a_ck_pair: assert property (p_ck_pair) else $error("clock pair split");
    property p_ck_half; $rose(ck) |-> ck [*4] ##1 !ck; endproperty
    a_ck_half: assert property (p_ck_half) else $error("clock half period");
    // Pins move on the falling link edge so the device sees them settled
    property p_cmd_fall; $changed(cs_n) |-> !ck; endproperty
    a_cmd_fall: assert property (p_cmd_fall) else $error("command off fall");
    property p_cmd_len; $fell(cs_n) |-> !cs_n [*8] ##1 cs_n; endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("select length");
    property p_rd_first; $rose(dq_d_oe) |-> dqs_d; endproperty
    a_rd_first: assert property (p_rd_first) else $error("read strobe phase");
    property p_rd_diff; dq_d_oe |-> dqs_n_d == !dqs_d; endproperty
    a_rd_diff: assert property (p_rd_diff) else $error("read strobe pair");
    property p_rd_end; $rose(dq_d_oe) |-> dq_d_oe [*8] ##[8:25] !dq_d_oe; endproperty
    a_rd_end: assert property (p_rd_end) else $error("read burst length");
    property p_no_fight; (dq_h_oe || dqs_h_oe) |-> !dq_d_oe; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data bus contention");
endmodule

// ==== ddr_pkg.sv ====
// Shared constants and types for the DDR3 command link and its two ends
package ddr_pkg;
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
        CMD_WR  = 3'h4, CMD_RD  = 3'h5, CMD_ZQ  = 3'h6, CMD_NOP = 3'h7
    } cmd_t;
    localparam int BA_W   = 3;
    localparam int A_W    = 14;
    localparam int COL_W  = 10;
    localparam int DQ_W   = 8;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int MR0_BL_LSB   = 0;
    localparam int MR0_BT_BIT   = 3;
    localparam int MR0_CL_LSB   = 4;
    localparam int MR1_AL_LSB   = 3;
    localparam int MR1_TDQS_BIT = 11;
    localparam int MR2_CWL_LSB  = 3;
    localparam logic [4:0]  CL_BASE  = 5'h04;
    localparam logic [4:0]  CWL_BASE = 5'h05;
    localparam logic [13:0] MR0_RST  = 14'h0010;
    localparam logic [1:0]  BL_FIX8  = 2'h0;
    localparam logic [1:0]  BL_OTF   = 2'h1;
    localparam logic [1:0]  BL_FIX4  = 2'h2;
    localparam logic [1:0]  AL_CL1   = 2'h1;
    localparam logic [1:0]  AL_CL2   = 2'h2;
    localparam logic [3:0]  BEATS_BL8 = 4'h8;
    localparam logic [3:0]  BEATS_BC4 = 4'h4;
    localparam int MEM_DEPTH = 128;
    localparam int MEM_AW    = $clog2(MEM_DEPTH);
    localparam logic [2:0] CK_HALF  = 3'h4;
    localparam logic [2:0] DQS_MID  = 3'h1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFI_NORM_NS  = 7800;
    localparam int REFI_HOT_NS   = 3900;
    localparam logic [9:0] REFI_NORM_CYC = 10'(REFI_NORM_NS / CLK_PERIOD_NS);
    localparam logic [9:0] REFI_HOT_CYC  = 10'(REFI_HOT_NS / CLK_PERIOD_NS);
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WD0    = 8'h08;
    localparam logic [7:0] OFS_WD1    = 8'h0c;
    localparam logic [7:0] OFS_WMASK  = 8'h10;
    localparam logic [7:0] OFS_CFG    = 8'h14;
    localparam logic [7:0] OFS_RD0    = 8'h18;
    localparam logic [7:0] OFS_RD1    = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam int CMD_CKE_BIT  = 8;
    localparam int ADDR_BA_LSB  = 16;
    localparam int CFG_RL_LSB   = 0;
    localparam int CFG_WL_LSB   = 8;
    localparam int CFG_BC4_BIT  = 16;
    localparam int CFG_HOT_BIT  = 17;
    localparam int CFG_REF_BIT  = 18;
    localparam logic [31:0] CFG_RST = 32'h0000_0505;
endpackage

// ==== ddr_sync.sv ====
// Two-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
module ddr_sync #(
    parameter int W = 1
) (
    input  logic         ref_clk,
    input  logic         sys_rst,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t r, n;
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign q = r.s2;
endmodule
